// File: hdl/irq_enable_map.vh
`ifndef IRQ_ENABLE_MAP_VH
`define IRQ_ENABLE_MAP_VH

// Register byte offsets on the Wishbone slave.
`define OFS_ENABLE_2          4'h0
`define OFS_ENABLE_3          4'h4
`define OFS_EVENT_STATUS      4'h8
`define OFS_EVENT_MASK        4'hc

// Reset values.
`define ENABLE_2_RESET        8'h00
`define ENABLE_3_RESET        8'h00
`define EVENT_STATUS_RESET    12'h000
`define EVENT_MASK_RESET      12'h000

// Second enable register: field positions and implemented bits.
`define EN2_OSC_FAIL_BIT      7
`define EN2_COMPARATOR_BIT    6
`define EN2_BUS_COLLISION_BIT 3
`define EN2_LOW_VOLTAGE_BIT   2
`define EN2_TIMER3_BIT        1
`define EN2_RW_MASK           8'hce

// Third enable register: field positions and implemented bits.
`define EN3_LCD_BIT           6
`define EN3_SERIAL2_RX_BIT    5
`define EN3_SERIAL2_TX_BIT    4
`define EN3_CHARGE_TIME_BIT   3
`define EN3_CAPCOMP2_BIT      2
`define EN3_CAPCOMP1_BIT      1
`define EN3_RTC_BIT           0
`define EN3_RW_MASK           8'h4f

// Source numbering used by flag, request, status and mask vectors.
`define NUM_SOURCES           12
`define SRC_OSC_FAIL          0
`define SRC_COMPARATOR        1
`define SRC_BUS_COLLISION     2
`define SRC_LOW_VOLTAGE       3
`define SRC_TIMER3            4
`define SRC_LCD               5
`define SRC_SERIAL2_RX        6
`define SRC_SERIAL2_TX        7
`define SRC_CHARGE_TIME       8
`define SRC_CAPCOMP2          9
`define SRC_CAPCOMP1          10
`define SRC_RTC               11

`endif

// File: hdl/event_status_bank.v
`default_nettype none

module event_status_bank #(
	parameter WIDTH = 12
) (
	// Clock and reset
	input  wire             clock,
	input  wire             rst,
	// Events from the block
	input  wire [WIDTH-1:0] event_in,
	// Software access
	input  wire             clear_we,
	input  wire [WIDTH-1:0] clear_data,
	input  wire             mask_we,
	input  wire [WIDTH-1:0] mask_data,
	// State
	output reg  [WIDTH-1:0] status_reg,
	output reg  [WIDTH-1:0] mask_reg,
	output reg              irq_reg
);

	genvar i;
	generate
		for (i = 0; i < WIDTH; i = i + 1)
		begin : bit_cell
			// A new event beats a write-one-to-clear in the same cycle so it is never lost.
			always @(posedge clock)
			begin
				if (rst)
					status_reg[i] <= 1'b0;
				else if (event_in[i])
					status_reg[i] <= 1'b1;
				else if (clear_we && clear_data[i])
					status_reg[i] <= 1'b0;
			end
		end
	endgenerate

	always @(posedge clock)
	begin
		if (rst)
		begin
			mask_reg <= {WIDTH{1'b0}};
			irq_reg  <= 1'b0;
		end
		else
		begin
			if (mask_we)
				mask_reg <= mask_data;
			irq_reg <= |(status_reg & mask_reg);
		end
	end

endmodule // event_status_bank

`default_nettype wire

// File: hdl/peripheral_irq_enable_regs.v
// Operation
// - Second register bit 2 is read/write low-voltage enable, one permits, resets zero.
// - Second register bit 1 is read/write timer 3 overflow enable, resets zero.
// - Second register: bits 7,6,3 read/write reset zero; bits 5-4 and 0 read zero.
// - Third register: bit 7 reads zero; bits 5,4 read-only; bits 3-0 read/write.
`include "irq_enable_map.vh"
`default_nettype none

module peripheral_irq_enable_regs #(
	parameter NSRC = `NUM_SOURCES
) (
	// Clock and reset
	input  wire            clock,
	input  wire            rst,
	// Wishbone slave
	input  wire            wb_cyc_i,
	input  wire            wb_stb_i,
	input  wire            wb_we_i,
	input  wire [3:0]      wb_adr_i,
	input  wire [3:0]      wb_sel_i,
	input  wire [31:0]     wb_dat_i,
	output reg  [31:0]     wb_dat_o,
	output reg             wb_ack_o,
	// Peripheral pending flags
	input  wire [NSRC-1:0] pending_flags,
	// Second serial port enable state, owned by that port
	input  wire            serial2_rx_int_enable_in,
	input  wire            serial2_tx_int_enable_in,
	// LCD controller waveform state
	input  wire            lcd_type_b_waveform,
	input  wire            lcd_non_static_mode,
	// Gated requests toward the central interrupt logic
	output reg  [NSRC-1:0] int_request,
	// Event interrupt
	output wire            irq
);

	reg  [7:0]      enable_2_reg;
	reg  [7:0]      enable_2_next;
	reg  [7:0]      enable_3_reg;
	reg  [7:0]      enable_3_next;
	reg  [NSRC-1:0] enable_vec;
	reg  [NSRC-1:0] request_next;
	reg  [31:0]     read_next;
	wire            access;
	wire            wr;
	wire [NSRC-1:0] status_reg;
	wire [NSRC-1:0] mask_reg;
	wire            irq_reg;
	wire            status_clear_we;
	wire            mask_we;
	wire [NSRC-1:0] lane_data;
	wire            lanes_full;

	// One new access is taken per request; ack drops the cycle after it rises.
	assign access = wb_cyc_i && wb_stb_i && !wb_ack_o;
	assign wr     = access && wb_we_i;

	// Wider registers need both low byte lanes so a half write never clears a stray bit.
	assign lanes_full      = wb_sel_i[0] && wb_sel_i[1];
	assign lane_data       = wb_dat_i[NSRC-1:0];
	assign status_clear_we = wr && lanes_full && (wb_adr_i == `OFS_EVENT_STATUS);
	assign mask_we         = wr && lanes_full && (wb_adr_i == `OFS_EVENT_MASK);

	always @*
	begin
		enable_2_next = enable_2_reg;
		if (wr && wb_sel_i[0] && (wb_adr_i == `OFS_ENABLE_2))
			enable_2_next = wb_dat_i[7:0] & `EN2_RW_MASK;
	end

	always @*
	begin
		enable_3_next = enable_3_reg;
		if (wr && wb_sel_i[0] && (wb_adr_i == `OFS_ENABLE_3))
			enable_3_next = wb_dat_i[7:0] & `EN3_RW_MASK;
		// Serial port enables are read-only here; software writes cannot reach them.
		enable_3_next[`EN3_SERIAL2_RX_BIT] = serial2_rx_int_enable_in;
		enable_3_next[`EN3_SERIAL2_TX_BIT] = serial2_tx_int_enable_in;
	end

	always @(posedge clock)
	begin
		if (rst)
		begin
			enable_2_reg <= `ENABLE_2_RESET;
			enable_3_reg <= `ENABLE_3_RESET;
		end
		else
		begin
			enable_2_reg <= enable_2_next;
			enable_3_reg <= enable_3_next;
		end
	end

	always @*
	begin
		enable_vec = {NSRC{1'b0}};
		enable_vec[`SRC_OSC_FAIL]      = enable_2_reg[`EN2_OSC_FAIL_BIT];
		enable_vec[`SRC_COMPARATOR]    = enable_2_reg[`EN2_COMPARATOR_BIT];
		enable_vec[`SRC_BUS_COLLISION] = enable_2_reg[`EN2_BUS_COLLISION_BIT];
		enable_vec[`SRC_LOW_VOLTAGE]   = enable_2_reg[`EN2_LOW_VOLTAGE_BIT];
		enable_vec[`SRC_TIMER3]        = enable_2_reg[`EN2_TIMER3_BIT];
		enable_vec[`SRC_LCD]           = enable_3_reg[`EN3_LCD_BIT] && lcd_type_b_waveform
			&& lcd_non_static_mode;
		enable_vec[`SRC_SERIAL2_RX]    = enable_3_reg[`EN3_SERIAL2_RX_BIT];
		enable_vec[`SRC_SERIAL2_TX]    = enable_3_reg[`EN3_SERIAL2_TX_BIT];
		enable_vec[`SRC_CHARGE_TIME]   = enable_3_reg[`EN3_CHARGE_TIME_BIT];
		enable_vec[`SRC_CAPCOMP2]      = enable_3_reg[`EN3_CAPCOMP2_BIT];
		enable_vec[`SRC_CAPCOMP1]      = enable_3_reg[`EN3_CAPCOMP1_BIT];
		enable_vec[`SRC_RTC]           = enable_3_reg[`EN3_RTC_BIT];
	end

	// Flags are only read, never stored here, so disabling a source cannot lose its flag.
	always @*
	begin
		request_next = pending_flags & enable_vec;
	end

	always @*
	begin
		read_next = 32'h0000_0000;
		case (wb_adr_i)
			`OFS_ENABLE_2:
				read_next[7:0] = enable_2_reg;
			`OFS_ENABLE_3:
				read_next[7:0] = enable_3_reg;
			`OFS_EVENT_STATUS:
				read_next[NSRC-1:0] = status_reg;
			`OFS_EVENT_MASK:
				read_next[NSRC-1:0] = mask_reg;
			default:
				read_next = 32'h0000_0000;
		endcase
	end

	always @(posedge clock)
	begin
		if (rst)
		begin
			wb_ack_o    <= 1'b0;
			wb_dat_o    <= 32'h0000_0000;
			int_request <= {NSRC{1'b0}};
		end
		else
		begin
			wb_ack_o    <= access;
			int_request <= request_next;
			if (access && !wb_we_i)
				wb_dat_o <= read_next;
		end
	end

	// A status bit records each cycle a gated request is raised.
	event_status_bank #(
		.WIDTH(NSRC)
	) events (
		.clock     (clock),
		.rst       (rst),
		.event_in  (request_next),
		.clear_we  (status_clear_we),
		.clear_data(lane_data),
		.mask_we   (mask_we),
		.mask_data (lane_data),
		.status_reg(status_reg),
		.mask_reg  (mask_reg),
		.irq_reg   (irq_reg)
	);

	assign irq = irq_reg;

endmodule // peripheral_irq_enable_regs

`default_nettype wire

// File: testbench/peripheral_irq_enable_regs_props.sv
`default_nettype none
module peripheral_irq_enable_regs_props #(
	parameter NSRC = 12
) (
	// Bus and system
	input wire logic            clock,
	input wire logic            rst,
	input wire logic            wb_cyc_i,
	input wire logic            wb_stb_i,
	input wire logic            wb_we_i,
	input wire logic            wb_ack_o,
	input wire logic [3:0]      wb_adr_i,
	input wire logic [31:0]     wb_dat_o,
	// Requests
	input wire logic [NSRC-1:0] pending_flags,
	input wire logic [NSRC-1:0] int_request,
	input wire logic            lcd_type_b_waveform,
	input wire logic            lcd_non_static_mode,
	input wire logic            irq
);
	default clocking @(posedge clock); endclocking
	default disable iff (rst);
	ack_pulse_a: assert property (wb_ack_o |=> !wb_ack_o) else $error("ack held too long");
	ack_timing_a: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o) else $error("ack late");
	reset_clear_a: assert property ($fell(rst) |-> !wb_ack_o && int_request == 0 && !irq) else $error("reset state");
	req_flag_a: assert property ((int_request & ~$past(pending_flags)) == 0) else $error("request without flag");
	lcd_qual_a: assert property (int_request[5] |-> $past(lcd_type_b_waveform && lcd_non_static_mode))
		else $error("lcd request unqualified");
	// Read data only counts on a read ack, since it holds across writes.
	en2_zero_a: assert property (wb_ack_o && !$past(wb_we_i) && $past(wb_adr_i) == 4'h0 |->
		(wb_dat_o & 32'hffffff31) == 0) else $error("reserved bits set");
	en3_zero_a: assert property (wb_ack_o && !$past(wb_we_i) && $past(wb_adr_i) == 4'h4 |->
		(wb_dat_o & 32'hffffff80) == 0) else $error("reserved bits set");
	unmapped_zero_a: assert property (wb_ack_o && !$past(wb_we_i) && $past(wb_adr_i[1:0]) != 2'h0 |->
		wb_dat_o == 0) else $error("unmapped read not zero");
endmodule // peripheral_irq_enable_regs_props
bind peripheral_irq_enable_regs peripheral_irq_enable_regs_props #(.NSRC(NSRC)) props (.clock(clock), .rst(rst),
	.wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_ack_o(wb_ack_o), .wb_adr_i(wb_adr_i),
	.wb_dat_o(wb_dat_o), .pending_flags(pending_flags), .int_request(int_request),
	.lcd_type_b_waveform(lcd_type_b_waveform), .lcd_non_static_mode(lcd_non_static_mode), .irq(irq));
`default_nettype wire

// File: testbench/peripheral_irq_enable_regs_test.sv
`default_nettype none
module peripheral_irq_enable_regs_test;
	timeunit 1ns;
	timeprecision 1ns;
	`define CHK(a, b) begin total_checks++; if ((a) !== (b)) begin failures++; \
		$display("CHECK FAILED t=%0t %h %h", $time, a, b); end end
	logic        clock = 0, rst = 1, cyc = 0, stb = 0, we = 0, s2rx = 0, s2tx = 0, lb = 0, ln = 0, ack, irq;
	logic [3:0]  adr = 0, sel = 0;
	logic [31:0] dat = 0, rd, dat_o;
	logic [11:0] flags = 0, req;
	int          failures = 0, total_checks = 0;
	initial forever #25 clock = ~clock;
	peripheral_irq_enable_regs DUT (.clock(clock), .rst(rst), .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we),
		.wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(dat), .wb_dat_o(dat_o), .wb_ack_o(ack), .pending_flags(flags),
		.serial2_rx_int_enable_in(s2rx), .serial2_tx_int_enable_in(s2tx), .lcd_type_b_waveform(lb),
		.lcd_non_static_mode(ln), .int_request(req), .irq(irq));
	// Entering at a fresh edge keeps cyc low one full cycle between cycles.
	task automatic bus(input logic w, input logic [3:0] a, s, input logic [31:0] d);
		@(posedge clock);
		cyc <= 1;
		stb <= 1;
		we <= w;
		adr <= a;
		sel <= s;
		dat <= d;
		do @(posedge clock); while (ack !== 1'b1);
		rd = dat_o;
		cyc <= 0;
		stb <= 0;
	endtask
	task automatic t_reset;
		bus(0, 4'h0, 4'hf, 0);
		`CHK(rd, 32'h0)
		bus(0, 4'h4, 4'hf, 0);
		`CHK(rd, 32'h0)
		bus(0, 4'h2, 4'hf, 0);
		`CHK(rd, 32'h0)
		$display("t_reset done");
	endtask
	task automatic t_en2;
		bus(1, 4'h0, 4'hf, 32'hff);
		bus(0, 4'h0, 4'hf, 0);
		`CHK(rd, 32'hce)
		flags <= 12'hfff;
		repeat (3) @(posedge clock);
		`CHK(req[4:0], 5'h1f)
		bus(1, 4'h0, 4'he, 32'h0);
		bus(0, 4'h0, 4'hf, 0);
		`CHK(rd, 32'hce)
		bus(1, 4'h0, 4'h1, 32'hf9);
		repeat (3) @(posedge clock);
		`CHK(req[4:0], 5'h07)
		$display("t_en2 done");
	endtask
	task automatic t_en3;
		s2rx <= 1;
		s2tx <= 1;
		bus(1, 4'h4, 4'h1, 32'hff);
		bus(0, 4'h4, 4'hf, 0);
		`CHK(rd, 32'h7f)
		`CHK(req[11:5], 7'h7e)
		lb <= 1;
		ln <= 1;
		s2rx <= 0;
		s2tx <= 0;
		bus(0, 4'h4, 4'hf, 0);
		repeat (2) @(posedge clock);
		`CHK(rd, 32'h4f)
		`CHK(req[7:5], 3'h1)
		ln <= 0;
		repeat (2) @(posedge clock);
		`CHK(req[5], 1'b0)
		lb <= 0;
		$display("t_en3 done");
	endtask
	task automatic t_irq;
		`CHK(irq, 1'b0)
		bus(1, 4'hc, 4'h1, 32'hfff);
		repeat (3) @(posedge clock);
		`CHK(irq, 1'b0)
		bus(1, 4'hc, 4'h3, 32'hfff);
		repeat (3) @(posedge clock);
		`CHK(irq, 1'b1)
		bus(0, 4'hc, 4'hf, 0);
		`CHK(rd, 32'hfff)
		bus(0, 4'h8, 4'hf, 0);
		`CHK(rd, 32'hfff)
		bus(1, 4'h8, 4'h3, 32'hfff);
		bus(0, 4'h8, 4'hf, 0);
		`CHK(rd, 32'hf07)
		`CHK(irq, 1'b1)
		flags <= 0;
		repeat (2) @(posedge clock);
		bus(1, 4'h8, 4'h3, 32'hfff);
		bus(0, 4'h8, 4'hf, 0);
		`CHK(rd, 32'h0)
		`CHK(irq, 1'b0)
		$display("t_irq done");
	endtask
	task automatic print_verdict;
		$display("checks %0d failures %0d", total_checks, failures);
		if (failures == 0 && total_checks > 0)
			$display("Testbench passed");
		else
			$display("Testbench failed");
		$finish;
	endtask
	initial
	begin
		repeat (2000) @(posedge clock);
		failures++;
		print_verdict;
	end
	initial
	begin
		repeat (12) @(posedge clock);
		rst <= 0;
		t_reset;
		t_en2;
		t_en3;
		t_irq;
		print_verdict;
	end
endmodule // peripheral_irq_enable_regs_test
`default_nettype wire
